// ===== logic/dmrom_map.svh
// Contract
// - Two 64-bit words per read, shared address
// - Memory enable low holds both outputs while test select is low
// - ROM enable low holds both outputs while test select is low
// - Enables may toggle every cycle
// - Contents fixed at build, never written
// - Address captured on rising clock edge
// - Each array 192 entries of 64 bits
// - Test select chooses which enables gate updates
`ifndef DMROM_MAP_SVH
`define DMROM_MAP_SVH

`define DMROM_DEPTH        192
`define DMROM_WORD_W       64
`define DMROM_ADDR_W       8
`define DMROM_SEED_FIRST   64'h5a3c_96e1_0f87_d24b
`define DMROM_SEED_SECOND  64'hc3a5_1e78_b40d_6f92

`define DMROM_OFS_CTRL     12'h000
`define DMROM_OFS_STATUS   12'h004
`define DMROM_OFS_COUNT    12'h008
`define DMROM_OFS_WORD1_LO 12'h00c
`define DMROM_OFS_WORD1_HI 12'h010

`define DMROM_CTRL_HOLD_BIT    0
`define DMROM_STAT_UPD_BIT     0
`define DMROM_STAT_TSEL_BIT    1
`define DMROM_STAT_ADDR_LSB    8
`define DMROM_CTRL_RESET       1'b0

`define DMROM_RESP_OKAY    2'b00
`define DMROM_RESP_SLVERR  2'b10

`endif

// ===== logic/dmrom_pkg.sv
package dmrom_pkg;
  typedef enum logic [1:0] {
    DMROM_SRC_NORMAL,
    DMROM_SRC_TEST
  } dmrom_src_t;

  typedef logic [63:0] dmrom_word_t;
endpackage

// ===== logic/dmrom_array.sv
`timescale 1ns/1ps
`include "dmrom_map.svh"
module dmrom_array
  import dmrom_pkg::*;
#(
  parameter int          DEPTH  = `DMROM_DEPTH,
  parameter int          ADDR_W = `DMROM_ADDR_W,
  parameter logic [63:0] SEED   = `DMROM_SEED_FIRST
) (
  input  wire logic [ADDR_W-1:0] addr_in,
  output dmrom_word_t            word_out
);
  if (DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : g_bad_depth
    $error("dmrom_array: depth does not fit address width");
  end

  // Build-time constant word for one entry
  function automatic dmrom_word_t entry_word(input int idx);
    logic [7:0]  b;
    dmrom_word_t w;
    b = idx[7:0];
    w = {8{b}} ^ SEED;
    return {w[50:0], w[63:51]} ^ {56'h0, b};
  endfunction

  dmrom_word_t mem [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    assign mem[i] = entry_word(i);
  end

  always_comb begin
    if (int'(addr_in) < DEPTH) begin
      word_out = mem[addr_in];
    end else begin
      word_out = '0;
    end
  end
endmodule

// ===== logic/dmrom_top.sv
`timescale 1ns/1ps
`include "dmrom_map.svh"
module dmrom_top
  import dmrom_pkg::*;
#(
  parameter int DEPTH  = `DMROM_DEPTH,
  parameter int ADDR_W = `DMROM_ADDR_W
) (
  input  wire logic              CORE_CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [ADDR_W-1:0] TEST_ADDR_IN,
  input  wire logic              MEMORY_ENABLE_IN,
  input  wire logic              ROM_ENABLE_IN,
  input  wire logic              TEST_SELECT_IN,
  input  wire logic              TEST_ENABLE_IN,
  output logic [63:0]            WORD_OUT_FIRST_OUT,
  output logic [63:0]            WORD_OUT_SECOND_OUT,
  input  wire logic [11:0]       S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [11:0]       S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);
  if (ADDR_W != `DMROM_ADDR_W || DEPTH != `DMROM_DEPTH) begin : g_bad_size
    $error("dmrom_top: only the documented geometry is supported");
  end

  // Read path
  dmrom_src_t        src;
  logic [ADDR_W-1:0] sel_addr;
  logic              upd;
  dmrom_word_t       rd_first;
  dmrom_word_t       rd_second;
  dmrom_word_t       first_q;
  dmrom_word_t       first_d;
  dmrom_word_t       second_q;
  dmrom_word_t       second_d;
  logic [ADDR_W-1:0] last_addr_q;
  logic [ADDR_W-1:0] last_addr_d;
  logic              last_upd_q;
  logic              last_upd_d;
  logic [31:0]       count_q;
  logic [31:0]       count_d;
  logic              hold_q;
  logic              hold_d;

  always_comb begin
    src = TEST_SELECT_IN ? DMROM_SRC_TEST : DMROM_SRC_NORMAL;
    case (src)
      DMROM_SRC_TEST: begin
        sel_addr = TEST_ADDR_IN;
        upd      = TEST_ENABLE_IN;
      end
      DMROM_SRC_NORMAL: begin
        sel_addr = ADDR_IN;
        upd      = MEMORY_ENABLE_IN && ROM_ENABLE_IN;
      end
      default: begin
        sel_addr = ADDR_IN;
        upd      = 1'b0;
      end
    endcase
    if (hold_q) begin
      upd = 1'b0;
    end
  end

  dmrom_array #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W),
    .SEED   (`DMROM_SEED_FIRST)
  ) u_array_first (
    .addr_in  (sel_addr),
    .word_out (rd_first)
  );

  dmrom_array #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W),
    .SEED   (`DMROM_SEED_SECOND)
  ) u_array_second (
    .addr_in  (sel_addr),
    .word_out (rd_second)
  );

  // Each edge decides on that cycle's enables and the hold bit alone
  always_comb begin
    first_d     = first_q;
    second_d    = second_q;
    last_addr_d = last_addr_q;
    count_d     = count_q;
    last_upd_d  = upd;
    if (upd) begin
      first_d     = rd_first;
      second_d    = rd_second;
      last_addr_d = sel_addr;
      count_d     = count_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      first_q     <= '0;
      second_q    <= '0;
      last_addr_q <= '0;
      last_upd_q  <= 1'b0;
      count_q     <= '0;
    end else begin
      first_q     <= first_d;
      second_q    <= second_d;
      last_addr_q <= last_addr_d;
      last_upd_q  <= last_upd_d;
      count_q     <= count_d;
    end
  end

  assign WORD_OUT_FIRST_OUT  = first_q;
  assign WORD_OUT_SECOND_OUT = second_q;

  // Register bus slave
  logic        aw_have_q;
  logic        aw_have_d;
  logic [11:0] aw_addr_q;
  logic [11:0] aw_addr_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0]  w_strb_q;
  logic [3:0]  w_strb_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status_word;

  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;

  always_comb begin
    status_word = '0;
    status_word[`DMROM_STAT_UPD_BIT]  = last_upd_q;
    status_word[`DMROM_STAT_TSEL_BIT] = TEST_SELECT_IN;
    status_word[`DMROM_STAT_ADDR_LSB +: ADDR_W] = last_addr_q;
  end

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    hold_d    = hold_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_d = 1'b1;
      aw_addr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_d = 1'b1;
      w_data_d = S_AXI_WDATA;
      w_strb_d = S_AXI_WSTRB;
    end
    if (aw_have_q && w_have_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      case (aw_addr_q)
        `DMROM_OFS_CTRL: begin
          bresp_d = `DMROM_RESP_OKAY;
          if (w_strb_q[0]) begin
            hold_d = w_data_q[`DMROM_CTRL_HOLD_BIT];
          end
        end
        `DMROM_OFS_STATUS, `DMROM_OFS_COUNT,
        `DMROM_OFS_WORD1_LO, `DMROM_OFS_WORD1_HI: begin
          bresp_d = `DMROM_RESP_OKAY;
        end
        default: begin
          bresp_d = `DMROM_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d  = `DMROM_RESP_OKAY;
      case (S_AXI_ARADDR)
        `DMROM_OFS_CTRL: begin
          rdata_d = {31'h0000_0000, hold_q};
        end
        `DMROM_OFS_STATUS: begin
          rdata_d = status_word;
        end
        `DMROM_OFS_COUNT: begin
          rdata_d = count_q;
        end
        `DMROM_OFS_WORD1_LO: begin
          rdata_d = first_q[31:0];
        end
        `DMROM_OFS_WORD1_HI: begin
          rdata_d = first_q[63:32];
        end
        default: begin
          rdata_d = '0;
          rresp_d = `DMROM_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `DMROM_RESP_OKAY;
      hold_q    <= `DMROM_CTRL_RESET;
      rvalid_q  <= 1'b0;
      rresp_q   <= `DMROM_RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      hold_q    <= hold_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end
endmodule

// ===== verification/dmrom_chk.sv
`timescale 1ns/1ps
`include "dmrom_map.svh"
module dmrom_chk (
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        MEMORY_ENABLE_IN,
  input wire logic        ROM_ENABLE_IN,
  input wire logic        TEST_SELECT_IN,
  input wire logic        TEST_ENABLE_IN,
  input wire logic [63:0] WORD_OUT_FIRST_OUT,
  input wire logic [63:0] WORD_OUT_SECOND_OUT,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic upd;
  assign upd = TEST_SELECT_IN ? TEST_ENABLE_IN : (MEMORY_ENABLE_IN & ROM_ENABLE_IN);
  mem_hold_a: assert property (
    !TEST_SELECT_IN && !MEMORY_ENABLE_IN |=> $stable(WORD_OUT_FIRST_OUT)
    && $stable(WORD_OUT_SECOND_OUT)) else $error("outputs moved, memory enable low");
  rom_hold_a: assert property (
    !TEST_SELECT_IN && !ROM_ENABLE_IN |=> $stable(WORD_OUT_FIRST_OUT)
    && $stable(WORD_OUT_SECOND_OUT)) else $error("outputs moved, rom enable low");
  test_hold_a: assert property (
    TEST_SELECT_IN && !TEST_ENABLE_IN |=> $stable(WORD_OUT_FIRST_OUT)
    && $stable(WORD_OUT_SECOND_OUT)) else $error("outputs moved, test enable low");
  first_cause_a: assert property (
    $changed(WORD_OUT_FIRST_OUT) |-> $past(upd)) else $error("first word moved unasked");
  second_cause_a: assert property (
    $changed(WORD_OUT_SECOND_OUT) |-> $past(upd)) else $error("second word moved unasked");
  read_lat_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
  ar_block_a: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read address taken while answering");
  bad_addr_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > `DMROM_OFS_WORD1_HI |=>
    S_AXI_RRESP == `DMROM_RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("bad address read");
  cover property (TEST_SELECT_IN && TEST_ENABLE_IN);
  cover property (MEMORY_ENABLE_IN && ROM_ENABLE_IN ##1 !MEMORY_ENABLE_IN);
  cover property (S_AXI_RVALID && S_AXI_RRESP == `DMROM_RESP_SLVERR);
endmodule
bind dmrom_top dmrom_chk chk (.*);

// ===== verification/dmrom_seq_model.sv
`timescale 1ns/1ps
module dmrom_seq_model (
  input  wire logic  clk_in,
  output logic [7:0] addr_out,
  output logic [7:0] test_addr_out,
  output logic       memory_enable_out,
  output logic       rom_enable_out,
  output logic       test_select_out,
  output logic       test_enable_out
);
  // Sequencer side: a new request on any cycle, enables may flip every cycle
  initial begin
    {addr_out, test_addr_out} = 16'h0;
    {test_select_out, test_enable_out, memory_enable_out, rom_enable_out} = 4'h0;
  end
  task drv(input logic [7:0] ad, input logic [7:0] ta, input logic [3:0] e);
    @(posedge clk_in);
    addr_out <= ad;
    test_addr_out <= ta;
    {test_select_out, test_enable_out, memory_enable_out, rom_enable_out} <= e;
  endtask
endmodule

// ===== verification/test_dual_microcode_rom.sv
`timescale 1ns/1ps
`include "dmrom_map.svh"
`define CK(x, y) begin compares++; if ((x) !== (y)) begin bad_count++; \
  $display("[ERR] %0t %h %h", $time, x, y); end end
module test_dual_microcode_rom;
  import dmrom_pkg::*;
  wire logic [7:0] a, ta;
  wire logic       m_en, r_en, t_sel, t_en;
  logic            c = 1'b0, rn = 1'b0, hd = 1'b0;
  logic [63:0]     w1, w2, x1 = 64'h0, x2 = 64'h0;
  logic [11:0]     awa = 12'h0, ara = 12'h0;
  logic [31:0]     wd = 32'h0, rdat;
  logic            awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic            awr, wrdy, bv, arr, rv;
  logic [1:0]      bresp, rresp;
  int              bad_count = 0, compares = 0, cnt = 0, i;
  logic [19:0]     tb [17] = '{20'h00ff3, 20'h01fe3, 20'h02003, 20'hbf003, 20'hc0003,
    20'hff003, 20'h0a001, 20'h0b002, 20'h0c003, 20'h0d000, 20'h0e003, 20'h141ec,
    20'h151f8, 20'h16bec, 20'h17004, 20'h00000, 20'h00000};
  initial forever #5 c = ~c;
  dmrom_seq_model p (.clk_in(c), .addr_out(a), .test_addr_out(ta), .memory_enable_out(m_en),
    .rom_enable_out(r_en), .test_select_out(t_sel), .test_enable_out(t_en));
  dmrom_top uut (.CORE_CLK_IN(c), .RST_N_IN(rn), .ADDR_IN(a), .TEST_ADDR_IN(ta),
    .MEMORY_ENABLE_IN(m_en), .ROM_ENABLE_IN(r_en), .TEST_SELECT_IN(t_sel),
    .TEST_ENABLE_IN(t_en), .WORD_OUT_FIRST_OUT(w1), .WORD_OUT_SECOND_OUT(w2),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));
  function logic [63:0] rom(input logic [7:0] k, input logic s);
    logic [63:0] w;
    w = {8{k}} ^ (s ? `DMROM_SEED_SECOND : `DMROM_SEED_FIRST);
    return (k < 8'd192) ? ({w[50:0], w[63:51]} ^ {56'h0, k}) : 64'h0;
  endfunction
  task print_verdict;
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One request per edge; checks the word taken at this edge for the previous request
  task st(input logic [19:0] v);
    logic [7:0] sa;
    p.drv(v[19:12], v[11:4], v[3:0]);
    #1;
    `CK(w1, x1)
    `CK(w2, x2)
    sa = v[3] ? v[11:4] : v[19:12];
    if (!hd && (v[3] ? v[2] : &v[1:0])) begin
      x1 = rom(sa, 1'b0);
      x2 = rom(sa, 1'b1);
      cnt++;
    end
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] dv, input logic [1:0] er);
    int n;
    @(posedge c);
    awa <= ad;
    wd <= dv;
    {awv, wv, br} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge c);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    `CK(bresp, er)
    if (n == 50) begin bad_count++; print_verdict; end
  endtask
  task rd(input logic [11:0] ad, input logic [31:0] ev, input logic [1:0] er);
    int n;
    @(posedge c);
    ara <= ad;
    {arv, rr} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge c);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    `CK(rdat, ev)
    `CK(rresp, er)
    if (n == 50) begin bad_count++; print_verdict; end
  endtask
  initial begin
    repeat (10) @(posedge c);
    rn <= 1'b1;
    for (i = 0; i < 17; i++) st(tb[i]);
    wr(`DMROM_OFS_CTRL, 32'h1, `DMROM_RESP_OKAY);
    hd = 1'b1;
    for (i = 0; i < 3; i++) st(20'h05003 & {20{i < 2}});
    wr(`DMROM_OFS_CTRL, 32'h0, `DMROM_RESP_OKAY);
    hd = 1'b0;
    rd(`DMROM_OFS_COUNT, 32'(cnt), `DMROM_RESP_OKAY);
    rd(`DMROM_OFS_STATUS, 32'h0000_be00, `DMROM_RESP_OKAY);
    rd(`DMROM_OFS_CTRL, 32'h0, `DMROM_RESP_OKAY);
    rd(`DMROM_OFS_WORD1_HI, x1[63:32], `DMROM_RESP_OKAY);
    wr(`DMROM_OFS_WORD1_LO, 32'hffff_ffff, `DMROM_RESP_OKAY);
    rd(`DMROM_OFS_WORD1_LO, x1[31:0], `DMROM_RESP_OKAY);
    rd(12'h100, 32'h0, `DMROM_RESP_SLVERR);
    wr(12'h100, 32'h1, `DMROM_RESP_SLVERR);
    rd(`DMROM_OFS_CTRL, 32'h0, `DMROM_RESP_OKAY);
    p.drv(8'h00, 8'h07, 4'hc);
    rd(`DMROM_OFS_STATUS, 32'h0000_0703, `DMROM_RESP_OKAY);
    print_verdict;
  end
endmodule
